/* inc/dmm_params.svh */
`ifndef DMM_PARAMS_SVH
`define DMM_PARAMS_SVH

// Register indices; byte address is four times the index
`define DMM_IDX_CTRL       6'h21
`define DMM_IDX_VOL_L      6'h1e
`define DMM_IDX_VOL_R      6'h1f
`define DMM_IDX_EN         6'h22
`define DMM_IDX_STAT       6'h23

// Control, volume and status register fields
`define DMM_B_DEEMPHASIS_SELECT_LO    1
`define DMM_B_DEEMPHASIS_SELECT_HI    2
`define DMM_B_MUTE         3
`define DMM_B_UNRAMP       9
`define DMM_B_RATE         10
`define DMM_B_SB           11
`define DMM_B_MONO         12
`define DMM_B_VU           8
`define DMM_B_BUSY         16

`define DMM_CTRL_W         16
`define DMM_CTRL_RST       16'h0008
`define DMM_VOL_RST        8'hc0
`define DMM_VOL_TOP        8'hc0
`define DMM_VOL_MUTE       8'h00

// Ramp divider: last sample count before a step
`define DMM_RATE_FAST_LAST 5'h01
`define DMM_RATE_SLOW_LAST 5'h1f

`define DMM_CLK_HZ         100000000
`define DMM_FS_HZ          48000

// De-emphasis shelf, Q14 magnitudes: y = b0*x - b1*x1 + a1*y1
`define DMM_DE_SHIFT       14
`define DMM_C32_B0         16'h2eea
`define DMM_C32_B1         16'h06c9
`define DMM_C32_A1         16'h17df
`define DMM_C44_B0         16'h283c
`define DMM_C44_B1         16'h07e4
`define DMM_C44_A1         16'h1fa8
`define DMM_C48_B0         16'h2687
`define DMM_C48_B1         16'h0862
`define DMM_C48_A1         16'h21db
`define DMM_GAIN_SHIFT     15

`define DMM_RESP_OK        2'b00
`define DMM_RESP_SLVERR    2'b10

`endif

/* inc/dmm_pkg.sv */
package dmm_pkg;
  typedef enum logic [1:0] {
    DMM_DE_NONE = 2'b00,
    DMM_DE_32K  = 2'b01,
    DMM_DE_44K  = 2'b10,
    DMM_DE_48K  = 2'b11
  } dmm_deemphasis_select_e;

  typedef enum logic [2:0] {
    DMM_SEL_CTRL  = 3'b000,
    DMM_SEL_VOL_L = 3'b001,
    DMM_SEL_VOL_R = 3'b010,
    DMM_SEL_EN    = 3'b011,
    DMM_SEL_STAT  = 3'b100,
    DMM_SEL_NONE  = 3'b111
  } dmm_sel_e;

  typedef struct packed {
    logic [15:0] b0;
    logic [15:0] b1;
    logic [15:0] a1;
  } dmm_coef_s;
endpackage

/* logic/dmm_fifo.sv */
module dmm_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   cnt;
  logic          wr;
  logic          rd;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign wr       = in_valid && in_ready;
  // Head word moves into the output register when it is free or being taken
  assign rd       = (cnt != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
      cnt  <= '0;
    end else begin
      if (wr) begin
        wptr <= wptr + 1'b1;
      end
      if (rd) begin
        rptr <= rptr + 1'b1;
      end
      cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (rd) begin
      out_valid <= 1'b1;
      out_data  <= mem[rptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

/* logic/dmm_filter.sv */
`include "dmm_params.svh"

module dmm_filter
  import dmm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FS_DIV = `DMM_CLK_HZ / `DMM_FS_HZ,
  parameter int FIFO_D = 16
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [15:0]       in_left,
  input  wire logic [15:0]       in_right,
  output logic                   out_valid,
  output logic [15:0]            out_left,
  output logic [15:0]            out_right,
  output logic                   left_converter_enable,
  output logic                   right_converter_enable,
  output logic                   sloping_stopband_select
);
  logic [`DMM_CTRL_W-1:0] ctrl;
  logic [7:0]             pend [2];
  logic [7:0]             act [2];
  logic [7:0]             cur [2];
  logic [7:0]             tgt [2];
  logic [15:0]            gain [2];
  logic [15:0]            res [2];
  logic [1:0]             en;
  logic                   aw_hold;
  logic                   w_hold;
  logic [ADDR_W-1:0]      aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;
  dmm_sel_e               wr_sel;
  logic [31:0]            rd_mux;
  logic [$clog2(FS_DIV)-1:0] fs_cnt;
  logic                   tick_fs;
  logic [4:0]             rate_cnt;
  logic [4:0]             rate_last;
  logic                   step;
  logic                   fifo_valid;
  logic [31:0]            fifo_data;
  logic signed [15:0]     smp [2];
  logic signed [16:0]     mix_sum;
  logic                   mono_act;
  logic                   mute_ctl;
  logic                   busy;

  function automatic dmm_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'b00) begin
      return DMM_SEL_NONE;
    end
    unique case (a[7:2])
      `DMM_IDX_CTRL:  return DMM_SEL_CTRL;
      `DMM_IDX_VOL_L: return DMM_SEL_VOL_L;
      `DMM_IDX_VOL_R: return DMM_SEL_VOL_R;
      `DMM_IDX_EN:    return DMM_SEL_EN;
      `DMM_IDX_STAT:  return DMM_SEL_STAT;
      default:        return DMM_SEL_NONE;
    endcase
  endfunction

  // Q15 gain for one 0.375 dB code; each 16 codes halve the gain
  function automatic logic [15:0] vol_gain(input logic [7:0] code);
    logic [7:0]  att;
    logic [15:0] base;
    att = `DMM_VOL_TOP - ((code > `DMM_VOL_TOP) ? `DMM_VOL_TOP : code);
    unique case (att[3:0])
      4'h0: base = 16'h8000;
      4'h1: base = 16'h7a99;
      4'h2: base = 16'h756c;
      4'h3: base = 16'h7077;
      4'h4: base = 16'h6bb5;
      4'h5: base = 16'h6729;
      4'h6: base = 16'h62cd;
      4'h7: base = 16'h5e9f;
      4'h8: base = 16'h5aa0;
      4'h9: base = 16'h56cc;
      4'ha: base = 16'h5321;
      4'hb: base = 16'h4f9e;
      4'hc: base = 16'h4c41;
      4'hd: base = 16'h4909;
      4'he: base = 16'h45f2;
      4'hf: base = 16'h42fd;
    endcase
    return (code == `DMM_VOL_MUTE) ? 16'h0000 : (base >> att[7:4]);
  endfunction

  function automatic dmm_coef_s deemphasis_select_coef(input dmm_deemphasis_select_e m);
    unique case (m)
      DMM_DE_32K: return '{`DMM_C32_B0, `DMM_C32_B1, `DMM_C32_A1};
      DMM_DE_44K: return '{`DMM_C44_B0, `DMM_C44_B1, `DMM_C44_A1};
      DMM_DE_48K: return '{`DMM_C48_B0, `DMM_C48_B1, `DMM_C48_A1};
      DMM_DE_NONE: return '{16'h0000, 16'h0000, 16'h0000};
    endcase
  endfunction

  // Register bus: address and data accepted in either order
  assign awready = !aw_hold;
  assign wready  = !w_hold;
  assign arready = !rvalid;
  assign wr_fire = aw_hold && w_hold && !bvalid;
  assign wr_sel  = reg_sel(aw_addr);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= `DMM_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wr_sel == DMM_SEL_NONE) ? `DMM_RESP_SLVERR : `DMM_RESP_OK;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= `DMM_CTRL_RST;
      en   <= '0;
    end else if (wr_fire) begin
      if (wr_sel == DMM_SEL_CTRL) begin
        if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
        if (w_strb[1]) ctrl[15:8] <= w_data[15:8];
      end
      if (wr_sel == DMM_SEL_EN && w_strb[0]) begin
        en <= w_data[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend <= '{`DMM_VOL_RST, `DMM_VOL_RST};
      act  <= '{`DMM_VOL_RST, `DMM_VOL_RST};
    end else if (wr_fire && (wr_sel == DMM_SEL_VOL_L || wr_sel == DMM_SEL_VOL_R)) begin
      if (w_strb[0]) begin
        pend[wr_sel == DMM_SEL_VOL_R] <= w_data[7:0];
      end
      if (w_strb[1] && w_data[`DMM_B_VU]) begin
        act[0] <= (wr_sel == DMM_SEL_VOL_L && w_strb[0]) ? w_data[7:0] : pend[0];
        act[1] <= (wr_sel == DMM_SEL_VOL_R && w_strb[0]) ? w_data[7:0] : pend[1];
      end
    end
  end

  always_comb begin
    unique case (reg_sel(araddr))
      DMM_SEL_CTRL:  rd_mux = {16'h0000, ctrl};
      DMM_SEL_VOL_L: rd_mux = {24'h000000, pend[0]};
      DMM_SEL_VOL_R: rd_mux = {24'h000000, pend[1]};
      DMM_SEL_EN:    rd_mux = {30'h00000000, en};
      DMM_SEL_STAT:  rd_mux = {15'h0000, busy, cur[1], cur[0]};
      DMM_SEL_NONE:  rd_mux = 32'h00000000;
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `DMM_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= (reg_sel(araddr) == DMM_SEL_NONE) ? `DMM_RESP_SLVERR : `DMM_RESP_OK;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  assign mute_ctl                = ctrl[`DMM_B_MUTE];
  assign left_converter_enable   = en[0];
  assign right_converter_enable  = en[1];
  assign sloping_stopband_select = ctrl[`DMM_B_SB];
  assign busy = (cur[0] != tgt[0]) || (cur[1] != tgt[1]);

  // Sample-rate enable and ramp step divider
  assign tick_fs   = (fs_cnt == ($clog2(FS_DIV))'(FS_DIV - 1));
  assign rate_last = ctrl[`DMM_B_RATE] ? `DMM_RATE_SLOW_LAST : `DMM_RATE_FAST_LAST;
  assign step      = tick_fs && (rate_cnt >= rate_last);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fs_cnt   <= '0;
      rate_cnt <= '0;
    end else begin
      fs_cnt <= tick_fs ? '0 : fs_cnt + 1'b1;
      if (step) begin
        rate_cnt <= '0;
      end else if (tick_fs) begin
        rate_cnt <= rate_cnt + 1'b1;
      end
    end
  end

  dmm_fifo #(
    .W     (32),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_left, in_right}),
    .out_valid (fifo_valid),
    .out_ready (tick_fs),
    .out_data  (fifo_data)
  );

  // Underrun plays silence
  assign smp[0]   = fifo_valid ? fifo_data[31:16] : 16'h0000;
  assign smp[1]   = fifo_valid ? fifo_data[15:0] : 16'h0000;
  assign mix_sum  = 17'(smp[0]) + 17'(smp[1]);
  assign mono_act = ctrl[`DMM_B_MONO] && (en[0] ^ en[1]);

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic signed [15:0] x;
    logic signed [15:0] x1;
    logic signed [15:0] y1;
    logic signed [15:0] yf;
    logic signed [34:0] acc;
    logic signed [32:0] prod;
    dmm_coef_s          c;

    assign tgt[ch]  = mute_ctl ? `DMM_VOL_MUTE :
                      ((act[ch] > `DMM_VOL_TOP) ? `DMM_VOL_TOP : act[ch]);
    assign gain[ch] = vol_gain(cur[ch]);

    always_ff @(posedge clk) begin
      if (!nrst) begin
        cur[ch] <= `DMM_VOL_MUTE;
      end else if (!mute_ctl && !ctrl[`DMM_B_UNRAMP]) begin
        cur[ch] <= tgt[ch];
      end else if (step && cur[ch] < tgt[ch]) begin
        cur[ch] <= cur[ch] + 1'b1;
      end else if (step && cur[ch] > tgt[ch]) begin
        cur[ch] <= cur[ch] - 1'b1;
      end
    end

    always_comb begin
      c = deemphasis_select_coef(dmm_deemphasis_select_e'(ctrl[`DMM_B_DEEMPHASIS_SELECT_HI:`DMM_B_DEEMPHASIS_SELECT_LO]));
      if (!en[ch]) begin
        x = 16'h0000;
      end else if (mono_act) begin
        x = mix_sum[16:1];
      end else begin
        x = smp[ch];
      end
      acc = $signed({1'b0, c.b0}) * x - $signed({1'b0, c.b1}) * x1
            + $signed({1'b0, c.a1}) * y1;
      yf  = (c.b0 == 16'h0000) ? x : acc[`DMM_DE_SHIFT+15:`DMM_DE_SHIFT];
      prod = $signed({1'b0, gain[ch]}) * yf;
      res[ch] = prod[`DMM_GAIN_SHIFT+15:`DMM_GAIN_SHIFT];
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        x1 <= '0;
        y1 <= '0;
      end else if (tick_fs) begin
        x1 <= x;
        y1 <= yf;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_left  <= '0;
      out_right <= '0;
    end else begin
      out_valid <= tick_fs;
      if (tick_fs) begin
        out_left  <= res[0];
        out_right <= res[1];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_vu_write;
    wr_fire && (wr_sel == DMM_SEL_VOL_L || wr_sel == DMM_SEL_VOL_R)
      && w_strb[1] && w_data[`DMM_B_VU];
  endsequence
  sequence s_mute_step;
    mute_ctl && step && cur[0] != `DMM_VOL_MUTE;
  endsequence

  property p_mute_down;
    s_mute_step |=> cur[0] == $past(cur[0]) - 8'h01;
  endproperty
  a_mute_down: assert property (p_mute_down) else $error("mute did not step down");
  property p_reset_muted;
    $rose(nrst) |-> mute_ctl && cur[0] == `DMM_VOL_MUTE && gain[1] == 16'h0000;
  endproperty
  a_reset_muted: assert property (p_reset_muted) else $error("not muted after reset");
  property p_unmute_up;
    !mute_ctl && ctrl[`DMM_B_UNRAMP] && step && cur[1] < tgt[1]
      |=> cur[1] == $past(cur[1]) + 8'h01;
  endproperty
  a_unmute_up: assert property (p_unmute_up) else $error("un-mute ramp missed a step");
  property p_unmute_jump;
    !mute_ctl && !ctrl[`DMM_B_UNRAMP] |=> cur[0] == $past(tgt[0]);
  endproperty
  a_unmute_jump: assert property (p_unmute_jump) else $error("un-mute did not jump");
  property p_step_rate;
    step |-> tick_fs && rate_cnt >= (ctrl[`DMM_B_RATE] ? 5'h1f : 5'h01);
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("ramp step too early");
  property p_step_only;
    mute_ctl && $past(mute_ctl) && cur[0] != $past(cur[0]) |-> $past(step);
  endproperty
  a_step_only: assert property (p_step_only) else $error("gain moved off step");
  property p_mono_mix;
    tick_fs && mono_act && en[0] && ctrl[`DMM_B_DEEMPHASIS_SELECT_HI:`DMM_B_DEEMPHASIS_SELECT_LO] == 2'b00
      && cur[0] == 8'hc0 |=> out_left == $past(mix_sum[16:1]) && out_right == 16'h0000;
  endproperty
  a_mono_mix: assert property (p_mono_mix) else $error("mono mix output wrong");
  property p_stereo;
    tick_fs && en[0] && en[1] && ctrl[`DMM_B_DEEMPHASIS_SELECT_HI:`DMM_B_DEEMPHASIS_SELECT_LO] == 2'b00
      && cur[0] == `DMM_VOL_TOP |=> out_left == $past(smp[0]);
  endproperty
  a_stereo: assert property (p_stereo) else $error("mix with both converters on");
  property p_code_gain;
    cur[1] == 8'h01 |-> gain[1] == 16'h0008;
  endproperty
  a_code_gain: assert property (p_code_gain) else $error("lowest code gain wrong");
  property p_vol_update;
    s_vu_write |=> act[0] == pend[0] && act[1] == pend[1];
  endproperty
  a_vol_update: assert property (p_vol_update) else $error("volume update not joint");
endmodule

/* bench/dmm_src.sv */
module dmm_src (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [3:0]  gap,
  input  wire logic [15:0] smp_l,
  input  wire logic [15:0] smp_r,
  input  wire logic        in_ready,
  output logic             in_valid,
  output logic [15:0]      in_left,
  output logic [15:0]      in_right,
  output int               accepted
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idle;

  initial begin
    in_valid = 1'b0;
    in_left = 16'h5a5a;
    in_right = 16'ha5a5;
    idle = 4'h0;
    accepted = 0;
  end

  // Word held until taken; idle lines toggle so stale data never looks valid
  always @(posedge clk) begin
    if (!nrst) begin
      in_valid <= 1'b0;
      idle <= 4'h0;
    end else if (!in_valid || in_ready) begin
      if (in_valid) begin
        accepted <= accepted + 1;
      end
      if (go && (in_valid ? gap == 4'h0 : idle == 4'h0)) begin
        in_valid <= 1'b1;
        in_left <= smp_l;
        in_right <= smp_r;
      end else begin
        in_valid <= 1'b0;
        in_left <= ~in_left;
        in_right <= ~in_right;
        idle <= in_valid ? gap : ((idle == 4'h0) ? 4'h0 : idle - 4'h1);
      end
    end
  end
endmodule

/* bench/test_dac_digital_mute_mix_filter.sv */
`include "dmm_params.svh"

module test_dac_digital_mute_mix_filter;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FSD = 8;
  localparam logic [7:0] A_CTRL = {`DMM_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_VL   = {`DMM_IDX_VOL_L, 2'b00};
  localparam logic [7:0] A_VR   = {`DMM_IDX_VOL_R, 2'b00};
  localparam logic [7:0] A_EN   = {`DMM_IDX_EN, 2'b00};
  localparam logic [7:0] A_ST   = {`DMM_IDX_STAT, 2'b00};

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  gap = 4'h0;
  logic [15:0] smp_l = 16'h1000;
  logic [15:0] smp_r = 16'h0800;
  logic        awready, wready, bvalid, arready, rvalid, in_valid, in_ready, out_valid;
  logic        lce, rce, sbs;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] in_left, in_right, out_left, out_right;
  int          accepted;
  int          tick_cnt = 0;
  int          num_errors = 0;
  int          cmp_count = 0;

  dmm_filter #(.FS_DIV(FSD)) DUT (
    .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .in_valid(in_valid), .in_ready(in_ready), .in_left(in_left), .in_right(in_right),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right),
    .left_converter_enable(lce), .right_converter_enable(rce),
    .sloping_stopband_select(sbs)
  );

  dmm_src SRC (
    .clk(clk), .nrst(nrst), .go(go), .gap(gap), .smp_l(smp_l), .smp_r(smp_r),
    .in_ready(in_ready), .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
    .accepted(accepted)
  );

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_smp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t sample got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    chk_val(32'(bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_val(d, exp);
    chk_val(32'(r), 32'(er));
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge clk); while (out_valid !== 1'b1);
    end
  endtask

  // Polls busy until the walk ends, then checks end code and duration
  task automatic ramp(input logic [31:0] ctrl, input logic [15:0] code, input int steps, tk);
    logic [31:0] st;
    logic [1:0]  r;
    int          t0;
    int          span;
    axi_wr(A_CTRL, ctrl);
    t0 = int'($time);
    axi_rd(A_ST, st, r);
    chk_val(st[16], 1);
    while (st[16] === 1'b1) axi_rd(A_ST, st, r);
    span = (int'($time) - t0) / 10 - steps * tk * FSD;
    chk_val(st[15:0], code);
    chk_val(32'(span > -2 * tk * FSD - 16 && span < 2 * tk * FSD + 16), 1);
    chk_val(32'(span + steps * tk * FSD <= (tk == 2 ? 513 : 8208) * FSD), 1);
  endtask

  initial begin
    int t;
    logic [31:0] d;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(A_CTRL, 32'h8);
    rd_chk(A_VL, 32'hc0);
    rd_chk(A_ST, 32'h0);
    rd_chk(8'h90, 32'h0, 2'b10);
    axi_wr(8'h85, 32'h0, 2'b10);
    rd_chk(A_CTRL, 32'h8);
    axi_wr(A_EN, 32'h3);
    t = tick_cnt;
    go <= 1'b1;
    @(posedge clk);
    while (in_ready === 1'b1) @(posedge clk);
    chk_val(32'(accepted >= 17 && accepted <= 18 + tick_cnt - t), 1);
    ticks(3);
    chk_smp(out_left, 16'h0);
    $display("test reset and fill done");
    axi_wr(A_CTRL, 32'h0);
    rd_chk(A_ST, 32'hc0c0);
    ticks(3);
    chk_val(32'(out_left != 0 && out_right != 0), 1);
    axi_wr(A_VL, 32'h00);
    rd_chk(A_ST, 32'hc0c0);
    axi_wr(A_VR, 32'h140);
    rd_chk(A_ST, 32'h4000);
    ticks(3);
    chk_smp(out_left, 16'h0);
    chk_val(32'(out_right != 0), 1);
    axi_wr(A_VL, 32'hc0);
    axi_wr(A_VR, 32'h1c0);
    $display("test volume done");
    ramp(32'h0208, 16'h0000, 192, 2);
    ramp(32'h0200, 16'hc0c0, 192, 2);
    ramp(32'h0208, 16'h0000, 192, 2);
    axi_wr(A_VL, 32'h10);
    axi_wr(A_VR, 32'h110);
    rd_chk(A_ST, 32'h0);
    ramp(32'h0600, 16'h1010, 16, 32);
    $display("test ramps done");
    axi_wr(A_CTRL, 32'h0);
    axi_wr(A_VL, 32'hc0);
    axi_wr(A_VR, 32'h1c0);
    rd_chk(A_ST, 32'hc0c0);
    axi_wr(A_EN, 32'h1);
    axi_wr(A_CTRL, 32'h1000);
    smp_r <= 16'hf000;
    ticks(20);
    chk_smp(out_left, 16'h0);
    chk_smp(out_right, 16'h0);
    chk_val({lce, rce}, 2'b10);
    smp_r <= 16'h1000;
    gap <= 4'h2;
    ticks(20);
    chk_val(32'(out_left != 0), 1);
    chk_smp(out_right, 16'h0);
    axi_wr(A_EN, 32'h3);
    smp_r <= 16'hf000;
    ticks(20);
    chk_val(32'(out_left != 0 && out_right != 0), 1);
    go <= 1'b0;
    ticks(24);
    chk_smp(out_left, 16'h0);
    chk_val(in_ready, 1);
    $display("test mono and drain done");
    for (int c = 0; c < 4; c++) begin
      d = 32'(c * 2) | (c[0] ? 32'h800 : 32'h0);
      axi_wr(A_CTRL, d);
      rd_chk(A_CTRL, d);
      chk_val(sbs, c[0]);
    end
    $display("test filter codes done");
    complete_run();
  end

  // Tests need about 15000 cycles; four times that means a hang
  initial begin
    #600000;
    num_errors++;
    complete_run();
  end
endmodule
